// ===== rtl/sri_pkg.sv
// Shared opcodes, frame shapes and timing for the security/ID command block.
package sri_pkg;

	// Opcodes handled by this block.
	localparam logic [7:0] OP_WREN  = 8'h06;
	localparam logic [7:0] OP_RDSR  = 8'h05;
	localparam logic [7:0] OP_PARAM = 8'h5a;
	localparam logic [7:0] OP_ERASE = 8'h44;
	localparam logic [7:0] OP_PROG  = 8'h42;
	localparam logic [7:0] OP_SREAD = 8'h48;
	localparam logic [7:0] OP_ID2   = 8'h92;
	localparam logic [7:0] OP_ID4   = 8'h94;
	localparam logic [7:0] OP_UID   = 8'h4b;

	// Frame geometry: opcode length in serial clocks, register bases and mode bits.
	localparam logic [11:0] OPC_CLKS = 12'h008;
	localparam logic [7:0]  SEC_BASE1 = 8'h10;
	localparam logic [7:0]  SEC_BASE2 = 8'h20;
	localparam logic [7:0]  SEC_BASE3 = 8'h30;
	localparam logic [7:0]  MODE_BITS = 8'hf0;

	// Busy durations of the model in mclk cycles; erase must exceed 256.
	localparam logic [15:0] ERASE_CYCLES = 16'h0400;
	localparam logic [15:0] PROG_CYCLES  = 16'h0040;

	// Host timing: half serial period and chip select high time.
	localparam logic [1:0] HALF_CYCLES = 2'h2;
	localparam logic [1:0] GAP_CYCLES  = 2'h3;

	// Bits carried per clock after the opcode.
	function automatic logic [2:0] op_width(input logic [7:0] op);
		return (op == OP_ID2) ? 3'h2 : (op == OP_ID4) ? 3'h4 : 3'h1;
	endfunction

	// Clocks used by the address field.
	function automatic logic [11:0] op_addr_clks(input logic [7:0] op);
		return (op == OP_ID2) ? 12'h00c : (op == OP_ID4) ? 12'h006 :
			(op == OP_UID || op == OP_RDSR || op == OP_WREN) ? 12'h000 : 12'h018;
	endfunction

	// Clocks after the opcode before the data phase.
	function automatic logic [11:0] op_lead(input logic [7:0] op);
		return (op == OP_PARAM || op == OP_SREAD || op == OP_UID) ? 12'h020 :
			(op == OP_ID2) ? 12'h010 : (op == OP_ID4) ? 12'h00c :
			(op == OP_ERASE || op == OP_PROG) ? 12'h018 : 12'h000;
	endfunction

	// Opcodes whose data phase is driven by the device.
	function automatic logic op_reads(input logic [7:0] op);
		return op == OP_RDSR || op == OP_PARAM || op == OP_SREAD ||
			op == OP_ID2 || op == OP_ID4 || op == OP_UID;
	endfunction

	// Host state machine.
	typedef enum logic [1:0] {H_IDLE, H_LOW, H_HIGH, H_GAP} sri_host_state_type;

endpackage

// ===== rtl/sri_spi_if.sv
// Serial link between the flash command end and its host.
`timescale 1ns/1ps
interface sri_spi_if;
	logic       cs_n;         // Chip select, active low.
	logic       sclk;         // Serial clock made by the host.
	logic [3:0] host_io_out;  // Host data lines.
	logic [3:0] host_io_oe;   // Host drives a line while high.
	logic [3:0] dev_io_out;   // Device data lines.
	logic [3:0] dev_io_oe;    // Device drives a line while high.
	logic [3:0] io;           // Resolved line level, pulled high when idle.

	// Resolve each line from the two enables.
	assign io = (host_io_oe & host_io_out) | (dev_io_oe & dev_io_out) |
		~(host_io_oe | dev_io_oe);

	modport host (output cs_n, output sclk, output host_io_out, output host_io_oe,
		input io);
	modport dev (input cs_n, input sclk, input io, output dev_io_out, output dev_io_oe);
endinterface

// ===== rtl/sri_flash_dev.sv
// Flash end: parameter table, security registers and ID reads.
`timescale 1ns/1ps
module sri_flash_dev #(
	parameter logic [7:0]    MFR_ID      = 8'h5a,                // Arbitrary value.
	parameter logic [7:0]    DEV_ID      = 8'h13,                // Arbitrary value.
	parameter logic [63:0]   UNIQUE_ID   = 64'h0123_4567_89ab_cdef, // Arbitrary value.
	parameter logic [2047:0] PARAM_TABLE = {128{16'h5aa5}}       // Byte n at [8n+7:8n].
) (
	// Clock and reset.
	input  wire logic       mclk,
	input  wire logic       rst_b,
	// Serial link.
	sri_spi_if.dev          spi,
	// User side.
	input  wire logic [2:0] secure_lock_bits,
	output logic            busy,
	output logic            write_enable_latch
);

	////////////////////////////////////////////////////////////////////////////
	// Frame tracking.

	logic        sclk_q;    // Serial clock one cycle ago.
	logic        cs_q;      // Chip select one cycle ago.
	logic [11:0] clk_cnt;   // Rising serial edges in this frame.
	logic [7:0]  opcode;    // Opcode shifted in.
	logic [23:0] addr;      // Address shifted in.
	logic [7:0]  rd_addr;   // Running byte pointer.
	logic        frame_ok;  // Command accepted at its opcode.
	logic [7:0]  in_sr;     // Program data shifter.
	logic [2:0]  in_bits;   // Program bits gathered.
	logic        prog_seen; // At least one byte programmed.
	logic [7:0]  out_sr;    // Output shifter.
	logic [2:0]  out_left;  // Output slots left in byte.
	logic [15:0] busy_cnt;  // Self-timed cycle counter.
	logic        erasing;   // Busy cycle is an erase.
	logic [1:0]  er_sel;    // Register being erased.
	logic [7:0]  er_ptr;    // Next byte to erase.
	logic [7:0]  sec_mem [0:767]; // Three security registers.

	wire sclk_rise = spi.sclk & ~sclk_q & ~spi.cs_n;
	wire sclk_fall = ~spi.sclk & sclk_q & ~spi.cs_n;
	wire cs_rise   = spi.cs_n & ~cs_q;

	// Shape of the current command.
	wire [2:0]  w        = sri_pkg::op_width(opcode);
	wire [11:0] aclk     = sri_pkg::op_addr_clks(opcode);
	wire [11:0] data_at  = sri_pkg::OPC_CLKS + sri_pkg::op_lead(opcode);
	wire        in_op    = clk_cnt < sri_pkg::OPC_CLKS;
	wire        in_addr  = !in_op && clk_cnt < sri_pkg::OPC_CLKS + aclk;
	wire        last_adr = in_addr && clk_cnt == sri_pkg::OPC_CLKS + aclk - 12'h001;
	wire        in_data  = !in_op && clk_cnt >= data_at;
	wire [7:0]  next_op  = {opcode[6:0], spi.io[0]};

	// Address shift by the command width.
	wire [23:0] next_addr = (w == 3'h4) ? {addr[19:0], spi.io[3:0]} :
		(w == 3'h2) ? {addr[21:0], spi.io[1:0]} : {addr[22:0], spi.io[0]};

	// Security register decode from bits 15..8; upper byte must be zero.
	wire       upper_zero = addr[23:16] == 8'h00;
	wire       sel1       = addr[15:8] == sri_pkg::SEC_BASE1;
	wire       sel2       = addr[15:8] == sri_pkg::SEC_BASE2;
	wire       sel3       = addr[15:8] == sri_pkg::SEC_BASE3;
	wire       sec_hit    = upper_zero && (sel1 || sel2 || sel3);
	wire [1:0] sec_sel    = sel3 ? 2'h2 : sel2 ? 2'h1 : 2'h0;
	wire       locked     = secure_lock_bits[sec_sel];
	wire [9:0] mem_idx    = {sec_sel, rd_addr};

	// Program is allowed only with the latch set on an unlocked register.
	wire prog_ok = opcode == sri_pkg::OP_PROG && frame_ok && write_enable_latch &&
		sec_hit && !locked;
	wire prog_byte = sclk_rise && in_data && prog_ok && in_bits == 3'h7;
	wire [7:0] prog_data = {in_sr[6:0], spi.io[0]};

	// Erase needs the latch, an unlocked register and select high right after 32.
	wire erase_go = cs_rise && opcode == sri_pkg::OP_ERASE && frame_ok &&
		clk_cnt == data_at && write_enable_latch && sec_hit && !locked;
	wire prog_go  = cs_rise && prog_ok && prog_seen;
	wire wren_go  = cs_rise && opcode == sri_pkg::OP_WREN && frame_ok &&
		clk_cnt == sri_pkg::OPC_CLKS;

	// Byte to send next, chosen by opcode.
	wire [7:0] param_byte = PARAM_TABLE[{rd_addr, 3'h0} +: 8];
	wire [7:0] uid_byte   = UNIQUE_ID[{~rd_addr[2:0], 3'h0} +: 8];
	wire [7:0] id_byte    = rd_addr[0] ? DEV_ID : MFR_ID;
	wire [7:0] sec_byte   = sec_hit ? sec_mem[mem_idx] : 8'hff;
	wire [7:0] fetch_byte =
		(opcode == sri_pkg::OP_RDSR)  ? {6'h00, write_enable_latch, busy} :
		(opcode == sri_pkg::OP_PARAM) ? param_byte :
		(opcode == sri_pkg::OP_SREAD) ? sec_byte :
		(opcode == sri_pkg::OP_UID)   ? uid_byte : id_byte;

	// Output slot: reload at a byte boundary, else keep shifting.
	wire       do_out   = sclk_fall && in_data && frame_ok && sri_pkg::op_reads(opcode);
	wire       reload   = out_left == 3'h0;
	wire [7:0] src_byte = reload ? fetch_byte : out_sr;
	wire [2:0] slots    = (w == 3'h4) ? 3'h1 : (w == 3'h2) ? 3'h3 : 3'h7;
	wire [3:0] drive    = (w == 3'h4) ? src_byte[7:4] :
		(w == 3'h2) ? {2'h0, src_byte[7:6]} : {2'h0, src_byte[7], 1'h0};
	wire [3:0] lanes    = (w == 3'h4) ? 4'hf : (w == 3'h2) ? 4'h3 : 4'h2;
	wire [7:0] next_sr  = (w == 3'h4) ? {src_byte[3:0], 4'h0} :
		(w == 3'h2) ? {src_byte[5:0], 2'h0} : {src_byte[6:0], 1'h0};

	////////////////////////////////////////////////////////////////////////////
	// Edge history.

	// Keep last levels of clock and select for edge detection.
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			sclk_q <= 1'b0;
			cs_q   <= 1'b1;
		end else begin
			sclk_q <= spi.sclk;
			cs_q   <= spi.cs_n;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Command input.

	// Count clocks and shift in opcode and address on rising edges.
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			clk_cnt <= 12'h000;
			opcode  <= 8'h00;
			addr    <= 24'h000000;
		end else if (spi.cs_n) begin
			clk_cnt <= 12'h000;
		end else if (sclk_rise) begin
			if (clk_cnt != 12'hfff) begin
				clk_cnt <= clk_cnt + 12'h001;
			end
			if (in_op) begin
				opcode <= next_op;
			end else if (in_addr) begin
				addr <= next_addr;
			end
		end
	end

	// Accept at the eighth bit; only status reads pass while busy.
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			frame_ok <= 1'b0;
		end else if (spi.cs_n) begin
			frame_ok <= 1'b0;
		end else if (sclk_rise && clk_cnt == 12'h007) begin
			frame_ok <= !busy || next_op == sri_pkg::OP_RDSR;
		end
	end

	// Byte pointer: loaded from address, wraps within 256.
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			rd_addr <= 8'h00;
		end else if (spi.cs_n) begin
			rd_addr <= 8'h00;
		end else if (sclk_rise && last_adr) begin
			rd_addr <= next_addr[7:0];
		end else if ((do_out && reload) || prog_byte) begin
			rd_addr <= rd_addr + 8'h01;
		end
	end

	// Gather program data bits during the data phase.
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			in_sr     <= 8'h00;
			in_bits   <= 3'h0;
			prog_seen <= 1'b0;
		end else if (spi.cs_n) begin
			in_bits   <= 3'h0;
			prog_seen <= 1'b0;
		end else if (sclk_rise && in_data && opcode == sri_pkg::OP_PROG) begin
			in_sr   <= prog_data;
			in_bits <= in_bits + 3'h1;
			if (prog_byte) begin
				prog_seen <= 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Data output.

	// Drive data on falling edges, MSB first; release when select is high.
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			out_sr         <= 8'h00;
			out_left       <= 3'h0;
			spi.dev_io_out <= 4'h0;
			spi.dev_io_oe  <= 4'h0;
		end else if (spi.cs_n) begin
			out_left      <= 3'h0;
			spi.dev_io_oe <= 4'h0;
		end else if (do_out) begin
			out_sr         <= next_sr;
			out_left       <= reload ? slots : out_left - 3'h1;
			spi.dev_io_out <= drive;
			spi.dev_io_oe  <= lanes;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Security memory and self-timed cycles.

	// Programming only clears bits; an erase writes FFh one byte per cycle.
	always_ff @(posedge mclk) begin
		if (erasing) begin
			sec_mem[{er_sel, er_ptr}] <= 8'hff;
		end else if (prog_byte) begin
			sec_mem[mem_idx] <= sec_mem[mem_idx] & prog_data;
		end
	end

	// Busy timer, erase walker and write enable latch.
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			busy_cnt           <= 16'h0000;
			busy               <= 1'b0;
			erasing            <= 1'b0;
			er_sel             <= 2'h0;
			er_ptr             <= 8'h00;
			write_enable_latch <= 1'b0;
		end else if (erase_go || prog_go) begin
			busy_cnt <= erase_go ? sri_pkg::ERASE_CYCLES : sri_pkg::PROG_CYCLES;
			busy     <= 1'b1;
			erasing  <= erase_go;
			er_sel   <= sec_sel;
			er_ptr   <= 8'h00;
		end else if (busy) begin
			busy_cnt <= busy_cnt - 16'h0001;
			if (erasing) begin
				er_ptr  <= er_ptr + 8'h01;
				erasing <= er_ptr != 8'hff;
			end
			if (busy_cnt == 16'h0001) begin
				busy               <= 1'b0;
				write_enable_latch <= 1'b0;
			end
		end else if (wren_go) begin
			write_enable_latch <= 1'b1;
		end
	end

endmodule

// ===== rtl/sri_spi_host.sv
// Host end: builds one command frame per request.
`timescale 1ns/1ps
module sri_spi_host (
	// Clock and reset.
	input  wire logic       mclk,
	input  wire logic       rst_b,
	// Serial link.
	sri_spi_if.host         spi,
	// Command request.
	input  wire logic       cmd_start,
	input  wire logic [7:0] cmd_op,
	input  wire logic [23:0] cmd_addr,
	input  wire logic [8:0] cmd_nbytes,
	input  wire logic [7:0] cmd_wdata,
	// Answer.
	output logic            cmd_busy,
	output logic            cmd_done,
	output logic [7:0]      rd_data,
	output logic            rd_valid
);

	////////////////////////////////////////////////////////////////////////////
	// Frame planning.

	sri_pkg::sri_host_state_type state; // Link phase.
	logic [7:0]  op;     // Opcode of this frame.
	logic [11:0] k;      // Clock index in the frame.
	logic [11:0] total;  // Clocks in the frame.
	logic [1:0]  div;    // Half period counter.
	logic [47:0] tx_sr;  // Opcode, address and mode bits.
	logic [7:0]  wdata;  // Program byte, repeated.
	logic [7:0]  rx_sr;  // Read shifter.
	logic [3:0]  rx_cnt; // Read bits gathered.

	wire        idle   = state == sri_pkg::H_IDLE;
	wire [7:0]  op_c   = idle ? cmd_op : op;
	wire [2:0]  w      = sri_pkg::op_width(op_c);
	wire [11:0] dat_at = sri_pkg::OPC_CLKS + sri_pkg::op_lead(op_c);
	wire        rd_op  = sri_pkg::op_reads(op_c);
	wire        has_dt = rd_op || op_c == sri_pkg::OP_PROG;
	wire [11:0] bits   = {cmd_nbytes, 3'h0};
	wire [11:0] dclks  = !has_dt ? 12'h000 : (w == 3'h4) ? {2'h0, bits[11:2]} :
		(w == 3'h2) ? {1'h0, bits[11:1]} : bits;

	// Next clock to drive and its bits; mode bits Fxh are sent by dual and quad.
	wire [11:0] j      = idle ? 12'h000 : k + 12'h001;
	wire        j_op   = j < sri_pkg::OPC_CLKS;
	wire        j_dat  = j >= dat_at;
	wire [2:0]  j_w    = j_op ? 3'h1 : w;
	wire [2:0]  pbit   = ~j[2:0];
	wire [47:0] tx_src = idle ? {cmd_op, cmd_addr, sri_pkg::MODE_BITS, 8'h00} : tx_sr;
	wire [3:0]  tx_bit = (j_dat && !rd_op) ? {3'h0, wdata[pbit]} :
		(j_w == 3'h4) ? tx_src[47:44] : (j_w == 3'h2) ? {2'h0, tx_src[47:46]} :
		{3'h0, tx_src[47]};
	wire [47:0] tx_nxt = (j_w == 3'h4) ? {tx_src[43:0], 4'h0} :
		(j_w == 3'h2) ? {tx_src[45:0], 2'h0} : {tx_src[46:0], 1'h0};
	wire [3:0]  tx_oe  = (j_dat && rd_op) ? 4'h0 : (j_w == 3'h4) ? 4'hf :
		(j_w == 3'h2) ? 4'h3 : 4'h1;

	// Sampling on the rising edge of a data clock.
	wire       k_dat  = rd_op && k >= dat_at;
	wire [7:0] rx_nxt = (w == 3'h4) ? {rx_sr[3:0], spi.io[3:0]} :
		(w == 3'h2) ? {rx_sr[5:0], spi.io[1:0]} : {rx_sr[6:0], spi.io[1]};
	wire [3:0] rx_sum = rx_cnt + {1'h0, w};
	wire       half   = div == sri_pkg::HALF_CYCLES - 2'h1;

	////////////////////////////////////////////////////////////////////////////
	// Link sequencer.

	// Select low, clock each bit, then hold select high for a gap.
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			state           <= sri_pkg::H_IDLE;
			op              <= 8'h00;
			k               <= 12'h000;
			total           <= 12'h000;
			div             <= 2'h0;
			tx_sr           <= 48'h0;
			wdata           <= 8'h00;
			spi.cs_n        <= 1'b1;
			spi.sclk        <= 1'b0;
			spi.host_io_out <= 4'h0;
			spi.host_io_oe  <= 4'h0;
			cmd_busy        <= 1'b0;
			cmd_done        <= 1'b0;
		end else begin
			cmd_done <= 1'b0;
			div      <= div + 2'h1;
			unique case (state)
				sri_pkg::H_IDLE: begin
					div <= 2'h0;
					if (cmd_start) begin
						op              <= cmd_op;
						wdata           <= cmd_wdata;
						total           <= dat_at + dclks;
						k               <= 12'h000;
						tx_sr           <= tx_nxt;
						spi.host_io_out <= tx_bit;
						spi.host_io_oe  <= tx_oe;
						spi.cs_n        <= 1'b0;
						cmd_busy        <= 1'b1;
						state           <= sri_pkg::H_LOW;
					end
				end
				sri_pkg::H_LOW: begin
					if (half) begin
						div      <= 2'h0;
						spi.sclk <= 1'b1;
						state    <= sri_pkg::H_HIGH;
					end
				end
				sri_pkg::H_HIGH: begin
					if (half) begin
						div      <= 2'h0;
						spi.sclk <= 1'b0;
						if (j == total) begin
							spi.cs_n       <= 1'b1;
							spi.host_io_oe <= 4'h0;
							state          <= sri_pkg::H_GAP;
						end else begin
							k               <= j;
							tx_sr           <= tx_nxt;
							spi.host_io_out <= tx_bit;
							spi.host_io_oe  <= tx_oe;
							state           <= sri_pkg::H_LOW;
						end
					end
				end
				sri_pkg::H_GAP: begin
					if (div == sri_pkg::GAP_CYCLES) begin
						cmd_busy <= 1'b0;
						cmd_done <= 1'b1;
						state    <= sri_pkg::H_IDLE;
					end
				end
			endcase
		end
	end

	// Gather read data on rising clock entry.
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			rx_sr    <= 8'h00;
			rx_cnt   <= 4'h0;
			rd_data  <= 8'h00;
			rd_valid <= 1'b0;
		end else begin
			rd_valid <= 1'b0;
			if (idle) begin
				rx_cnt <= 4'h0;
			end else if (state == sri_pkg::H_LOW && half && k_dat) begin
				rx_sr  <= rx_nxt;
				rx_cnt <= (rx_sum == 4'h8) ? 4'h0 : rx_sum;
				if (rx_sum == 4'h8) begin
					rd_data  <= rx_nxt;
					rd_valid <= 1'b1;
				end
			end
		end
	end

endmodule

// ===== sim/sri_checker.sv
// Concurrent checks on the serial link and the flash status outputs.
`timescale 1ns/1ps
module sri_checker (
	// Clock and reset.
	input wire logic       mclk,
	input wire logic       rst_b,
	// Serial link.
	input wire logic       cs_n,
	input wire logic       sclk,
	input wire logic [3:0] host_io_oe,
	input wire logic [3:0] dev_io_oe,
	input wire logic [3:0] io,
	// Flash status.
	input wire logic       busy,
	input wire logic       write_enable_latch
);
	// All checks share the one clock and reset.
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_b);

	////////////////////////////////////////////////////////////////////////////
	// Select held high over two edges.
	sequence s_deselected;
		cs_n ##1 cs_n;
	endsequence
	// Serial clock high over two edges.
	sequence s_clk_high;
		sclk ##1 sclk;
	endsequence
	// A self-timed cycle has just begun.
	sequence s_cycle_start;
		$rose(busy);
	endsequence

	////////////////////////////////////////////////////////////////////////////
	a_idle_release: assert property (s_deselected |-> dev_io_oe == 4'h0)
		else $error("Device drives a line while deselected.");
	a_no_contention: assert property ((host_io_oe & dev_io_oe) == 4'h0)
		else $error("Both ends drive one line.");
	a_line_width: assert property (dev_io_oe inside {4'h0, 4'h2, 4'h3, 4'hf})
		else $error("Device drives an odd set of lines.");
	a_busy_quiet: assert property (busy |-> !(dev_io_oe inside {4'h3, 4'hf}))
		else $error("Wide read answered while busy.");
	a_busy_select: assert property (s_cycle_start |-> cs_n)
		else $error("Timed cycle began inside a frame.");
	a_busy_lasts: assert property (s_cycle_start |=> busy [*8])
		else $error("Timed cycle ended at once.");
	a_latch_clear: assert property ($fell(busy) |-> ##[0:2] !write_enable_latch)
		else $error("Write enable survived the timed cycle.");
	a_latch_idle: assert property ($rose(write_enable_latch) |-> !$past(busy))
		else $error("Write enable set while busy.");
	a_out_steady: assert property (s_clk_high |-> $stable(io))
		else $error("Data moved while the serial clock was high.");
	a_drive_start: assert property ($rose(|dev_io_oe) |-> !cs_n && !sclk)
		else $error("Device began driving outside a low clock phase.");
endmodule

// ===== sim/security_register_and_id_commands_tb.sv
// Self-checking bench joining the host end and the flash end.
`timescale 1ns/1ps
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin errors++; \
	$display("BAD t=%0t got=%h exp=%h", $time, (g), (e)); end end
module security_register_and_id_commands_tb;
	// Arbitrary identity values and table contents.
	localparam logic [7:0]    MFR = 8'hc3;
	localparam logic [7:0]    DEV = 8'h27;
	localparam logic [63:0]   UID = 64'h1122_3344_5566_7788;
	localparam logic [2047:0] TAB = {64{32'h0f1e2d3c}};
	logic        mclk = 1'b0;
	logic        rst_b = 1'b0;
	logic        cmd_start = 1'b0;
	logic [7:0]  cmd_op = 8'h00;
	logic [23:0] cmd_addr = 24'h000000;
	logic [8:0]  cmd_nbytes = 9'h001;
	logic [7:0]  cmd_wdata = 8'h00;
	logic [2:0]  secure_lock_bits = 3'h0;
	logic        cmd_busy, cmd_done, rd_valid, busy, write_enable_latch;
	logic [7:0]  rd_data, wd, a;
	logic [7:0]  exp_q[$];      // Bytes the monitor still expects.
	int          errors = 0;
	int          total_checks = 0;

	// Free-running 100 MHz clock.
	initial begin
		forever #5 mclk = ~mclk;
	end

	sri_spi_if sri_spi_if_inst ();
	sri_spi_host sri_spi_host_inst (.mclk(mclk), .rst_b(rst_b), .spi(sri_spi_if_inst.host),
		.cmd_start(cmd_start), .cmd_op(cmd_op), .cmd_addr(cmd_addr), .cmd_nbytes(cmd_nbytes),
		.cmd_wdata(cmd_wdata), .cmd_busy(cmd_busy), .cmd_done(cmd_done), .rd_data(rd_data),
		.rd_valid(rd_valid));
	sri_flash_dev #(.MFR_ID(MFR), .DEV_ID(DEV), .UNIQUE_ID(UID), .PARAM_TABLE(TAB))
	sri_flash_dev_inst (.mclk(mclk), .rst_b(rst_b), .spi(sri_spi_if_inst.dev),
		.secure_lock_bits(secure_lock_bits), .busy(busy),
		.write_enable_latch(write_enable_latch));
	sri_checker sri_checker_inst (.mclk(mclk), .rst_b(rst_b), .cs_n(sri_spi_if_inst.cs_n),
		.sclk(sri_spi_if_inst.sclk), .host_io_oe(sri_spi_if_inst.host_io_oe),
		.dev_io_oe(sri_spi_if_inst.dev_io_oe), .io(sri_spi_if_inst.io), .busy(busy),
		.write_enable_latch(write_enable_latch));

	////////////////////////////////////////////////////////////////////////////
	// Issues one frame and waits for its completion pulse.
	task automatic run(input logic [7:0] op, input logic [23:0] ad = 24'h0,
		input logic [8:0] n = 9'h001, input logic [7:0] d = 8'h00);
		int k;
		@(posedge mclk);
		cmd_start <= 1'b1;
		cmd_op <= op;
		cmd_addr <= ad;
		cmd_nbytes <= n;
		cmd_wdata <= d;
		@(posedge mclk);
		cmd_start <= 1'b0;
		k = 0;
		do begin
			@(negedge mclk);
			k++;
		end while (cmd_done !== 1'b1 && k < 5000);
		if (k >= 5000) errors++;
		// The host must have closed the frame by the time it reports done.
		`CHK(cmd_busy, 1'b0)
	endtask

	// Waits for a timed cycle to finish.
	task automatic wait_idle();
		int k;
		k = 0;
		while (busy !== 1'b0 && k < 3000) begin
			@(negedge mclk);
			k++;
		end
		if (k >= 3000) errors++;
	endtask

	// Notes one byte that the link should return.
	task automatic want(input logic [7:0] b);
		exp_q.push_back(b);
	endtask

	// Prints the counts and the verdict, then stops.
	task automatic conclude();
		$display("Comparisons %0d, mismatches %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////////
	// Compares every received byte with the oldest noted one.
	always @(negedge mclk) begin
		if (rd_valid === 1'b1) begin
			if (exp_q.size() == 0) begin
				errors++;
				$display("BAD t=%0t got=%h exp=none", $time, rd_data);
			end else begin
				`CHK(rd_data, exp_q.pop_front())
			end
		end
	end

	// Cuts a hang short.
	initial begin
		#500000;
		errors++;
		conclude();
	end

	// Main sequence.
	initial begin
		void'($urandom(96549));
		repeat (12) @(posedge mclk);
		rst_b <= 1'b1;
		a = 8'($urandom);
		for (int i = 0; i < 3; i++) want(TAB[8 * int'(8'(a + i)) +: 8]);
		run(sri_pkg::OP_PARAM, {16'h0000, a}, 9'h003);
		for (int i = 0; i < 8; i++) want(i[0] ? DEV : MFR);
		run(sri_pkg::OP_ID2, 24'h0, 9'h004);
		run(sri_pkg::OP_ID4, 24'h0, 9'h004);
		for (int i = 0; i < 9; i++) want(UID[8 * (7 - i % 8) +: 8]);
		run(sri_pkg::OP_UID, 24'h0, 9'h009);
		$display("Test identity reads complete");
		run(sri_pkg::OP_WREN);
		`CHK(write_enable_latch, 1'b1)
		want(8'h02);
		run(sri_pkg::OP_RDSR);
		run(sri_pkg::OP_ERASE, 24'h001000);
		`CHK(busy, 1'b1)
		want(8'h03);
		run(sri_pkg::OP_RDSR);
		wait_idle();
		want(8'h00);
		run(sri_pkg::OP_RDSR);
		run(sri_pkg::OP_ERASE, 24'h003000);
		`CHK(busy, 1'b0)
		$display("Test erase complete");
		// Keep one bit set so that a wrongly accepted program of 00h shows.
		wd = (8'($urandom) & 8'h7f) | 8'h01;
		run(sri_pkg::OP_WREN);
		run(sri_pkg::OP_PROG, 24'h0010fe, 9'h003, wd);
		wait_idle();
		for (int i = 0; i < 3; i++) want(wd);
		want(8'hff);
		run(sri_pkg::OP_SREAD, 24'h0010fe, 9'h004);
		want(8'hff);
		run(sri_pkg::OP_SREAD, 24'h011000);
		$display("Test program complete");
		run(sri_pkg::OP_WREN);
		run(sri_pkg::OP_ERASE, 24'h002000);
		want(8'hff);
		run(sri_pkg::OP_SREAD, 24'h0010fe);
		wait_idle();
		want(wd);
		run(sri_pkg::OP_SREAD, 24'h0010fe);
		// Third register: erase, program one byte, read it and the next.
		run(sri_pkg::OP_WREN);
		run(sri_pkg::OP_ERASE, 24'h003000);
		wait_idle();
		run(sri_pkg::OP_WREN);
		run(sri_pkg::OP_PROG, 24'h003005, 9'h001, wd ^ 8'h3c);
		wait_idle();
		want(wd ^ 8'h3c);
		want(8'hff);
		run(sri_pkg::OP_SREAD, 24'h003005, 9'h002);
		$display("Test busy read complete");
		@(posedge mclk);
		secure_lock_bits <= 3'h1;
		run(sri_pkg::OP_WREN);
		run(sri_pkg::OP_ERASE, 24'h001000);
		`CHK(busy, 1'b0)
		run(sri_pkg::OP_WREN);
		run(sri_pkg::OP_PROG, 24'h0010fe, 9'h001, 8'h00);
		`CHK(busy, 1'b0)
		want(wd);
		run(sri_pkg::OP_SREAD, 24'h0010fe);
		`CHK(exp_q.size(), 0)
		$display("Test lock complete");
		conclude();
	end
endmodule
